// *** hdl/one_bit_acc_stage.sv ***
// Top of the one-bit loadable cascadable accumulator stage with register port.
//
// Behaviour
// RULE1: Clear high at a clock edge zeroes the bit, overriding everything else.
// RULE2: Enable low with no clear or load keeps the stored bit unchanged.
// RULE3: Power-up clears the register so the output starts low.
// RULE4: A global preload pulse gives the same cleared state as power-up.
// RULE5: Load high stores the load value bit whatever the enable.
// RULE6: Sum mode with enable adds operand and carry to the stored bit.
// RULE7: Difference mode with enable subtracts operand and borrow from the bit.
// RULE8: Carry output is combinational from operand and stored bit, not registered.
// RULE9: In sum mode carry in and carry out are active-high carries.
// RULE10: In difference mode carry in and out are active-low borrows.
// RULE11: Chaining joins each stage's carry output to the next carry input.
// RULE12: Load beats arithmetic; with load high mode and operand are ignored.
`timescale 1ns/1ps
module one_bit_acc_stage #(
	parameter int COUNT_W = acc_stage_pkg::COUNT_W
) (
	input logic clk,
	input logic rst,
	input logic global_preload_pulse,
	input logic sync_clear,
	input logic stage_enable,
	input logic load_select,
	input logic sum_select,
	input logic load_value_bit,
	input logic operand_bit,
	input logic carry_borrow_in,
	output logic accumulated_bit,
	output logic carry_borrow_out,
	input logic [acc_stage_pkg::ADDR_W-1:0] reg_addr,
	input logic [acc_stage_pkg::DATA_W-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [acc_stage_pkg::DATA_W-1:0] reg_rdata
);
	// Datapath nets
	logic stored_bit;
	logic arith_bit;
	logic cell_carry;
	logic eff_enable;
	logic arith_taken;
	logic bit_written;
	logic carry_seen;

	// Register state
	logic hold_reg;
	logic hold_next;
	logic [COUNT_W-1:0] update_count_reg;
	logic [COUNT_W-1:0] update_count_next;
	logic [COUNT_W-1:0] carry_count_reg;
	logic [COUNT_W-1:0] carry_count_next;
	logic [acc_stage_pkg::DATA_W-1:0] rdata_reg;
	logic [acc_stage_pkg::DATA_W-1:0] rdata_next;

	// Decode nets
	logic sel_status;
	logic sel_control;
	logic sel_update_count;
	logic sel_carry_count;
	logic wr_control;
	logic wr_update_count;
	logic wr_carry_count;
	logic [acc_stage_pkg::DATA_W-1:0] status_word;
	logic [acc_stage_pkg::DATA_W-1:0] control_word;
	logic [acc_stage_pkg::DATA_W-1:0] update_word;
	logic [acc_stage_pkg::DATA_W-1:0] carry_word;
	logic [acc_stage_pkg::DATA_W-1:0] read_mux;

	// Software hold suspends arithmetic only; clear and load still act
	assign eff_enable = stage_enable & ~hold_reg;

	// Arithmetic is taken only when no reset, clear or load claims the edge
	assign arith_taken = ~rst & ~sync_clear & ~load_select & eff_enable;
	assign bit_written = ~rst & ~sync_clear & (load_select | eff_enable);

	// Carry in sum mode is high-true, borrow in difference mode is low-true
	assign carry_seen = arith_taken & (sum_select ? cell_carry : ~cell_carry);

	// RULE6 RULE7 RULE9 RULE10 add subtract cell
	acc_bit_cell u_cell (
		.stored_bit(stored_bit),
		.operand_bit(operand_bit),
		.carry_borrow_in(carry_borrow_in),
		.sum_select(sum_select),
		.arith_bit(arith_bit),
		.carry_borrow_out(cell_carry)
	);

	// RULE1 RULE2 RULE3 RULE4 RULE5 RULE12 priority storage
	acc_bit_store u_store (
		.clk(clk),
		.rst(rst),
		.preload(global_preload_pulse),
		.clear(sync_clear),
		.load(load_select),
		.enable(eff_enable),
		.load_bit(load_value_bit),
		.arith_bit(arith_bit),
		.stored_bit(stored_bit)
	);

	assign accumulated_bit = stored_bit;

	// RULE8 unregistered carry
	// Left combinational so a chain of stages settles within one cycle
	assign carry_borrow_out = cell_carry;

	// Address decode
	assign sel_status = (reg_addr == acc_stage_pkg::OFF_STATUS);
	assign sel_control = (reg_addr == acc_stage_pkg::OFF_CONTROL);
	assign sel_update_count = (reg_addr == acc_stage_pkg::OFF_UPDATE_COUNT);
	assign sel_carry_count = (reg_addr == acc_stage_pkg::OFF_CARRY_COUNT);
	assign wr_control = reg_wr & sel_control;
	assign wr_update_count = reg_wr & sel_update_count;
	assign wr_carry_count = reg_wr & sel_carry_count;

	// Status shows live datapath state
	always_comb begin
		status_word = '0;
		status_word[acc_stage_pkg::ST_ACC_BIT] = stored_bit;
		status_word[acc_stage_pkg::ST_CARRY_BIT] = cell_carry;
		status_word[acc_stage_pkg::ST_SUM_BIT] = sum_select;
		status_word[acc_stage_pkg::ST_HOLD_BIT] = hold_reg;
		status_word[acc_stage_pkg::ST_ENABLE_BIT] = eff_enable;
	end

	// Control and counter read words, upper bits zero
	always_comb begin
		control_word = '0;
		control_word[acc_stage_pkg::CTL_HOLD_BIT] = hold_reg;
		update_word = '0;
		update_word[COUNT_W-1:0] = update_count_reg;
		carry_word = '0;
		carry_word[COUNT_W-1:0] = carry_count_reg;
	end

	// Read select; unmapped offsets answer zero
	assign read_mux = sel_status ? status_word :
		sel_control ? control_word :
		sel_update_count ? update_word :
		sel_carry_count ? carry_word : '0;

	// Read data only stands in the cycle after the strobe
	assign rdata_next = reg_rd ? read_mux : '0;

	// Hold bit write
	assign hold_next = wr_control ? reg_wdata[acc_stage_pkg::CTL_HOLD_BIT] : hold_reg;

	// Counters clear on write; an event in the same cycle still counts
	always_comb begin
		if (bit_written) begin
			update_count_next = wr_update_count ? COUNT_W'(1) : update_count_reg + 1'b1;
		end else if (wr_update_count) begin
			update_count_next = '0;
		end else begin
			update_count_next = update_count_reg;
		end
		if (carry_seen) begin
			carry_count_next = wr_carry_count ? COUNT_W'(1) : carry_count_reg + 1'b1;
		end else if (wr_carry_count) begin
			carry_count_next = '0;
		end else begin
			carry_count_next = carry_count_reg;
		end
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_reg <= acc_stage_pkg::HOLD_RESET;
			update_count_reg <= '0;
			carry_count_reg <= '0;
			rdata_reg <= '0;
		end else begin
			hold_reg <= hold_next;
			update_count_reg <= update_count_next;
			carry_count_reg <= carry_count_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// RULE1 clear wins
	a_clear_zeroes: assert property ( // RULE1
		@(posedge clk) disable iff (global_preload_pulse)
		sync_clear |=> (accumulated_bit == 1'b0) && $stable(update_count_reg)
	) else $error("clear did not zero the stored bit");

	// RULE2 idle edge holds
	a_idle_holds: assert property ( // RULE2
		@(posedge clk) disable iff (rst || global_preload_pulse)
		(!sync_clear && !load_select && !eff_enable) ##1 !rst
			|-> $stable(accumulated_bit)
	) else $error("stored bit changed while enable was low");

	// RULE3 power-up clear
	a_reset_low: assert property ( // RULE3
		@(posedge clk)
		rst |=> (accumulated_bit == 1'b0) && (update_count_reg == '0)
	) else $error("stored bit not low after reset");

	// RULE4 preload clear
	a_preload_low: assert property ( // RULE4
		@(posedge clk)
		global_preload_pulse |-> (accumulated_bit == 1'b0)
	) else $error("preload pulse did not clear the stored bit");

	// RULE5 load ignores enable
	a_load_stores: assert property ( // RULE5
		@(posedge clk) disable iff (rst || global_preload_pulse)
		(!sync_clear && load_select && !stage_enable)
			|=> accumulated_bit == $past(load_value_bit)
	) else $error("load with enable low did not store the load bit");

	// RULE6 add result
	a_add_result: assert property ( // RULE6
		@(posedge clk) disable iff (rst || global_preload_pulse)
		(arith_taken && sum_select)
			|=> accumulated_bit == ($past(accumulated_bit) ^ $past(operand_bit)
				^ $past(carry_borrow_in))
	) else $error("sum mode stored a wrong bit");

	// RULE7 subtract result
	a_sub_result: assert property ( // RULE7
		@(posedge clk) disable iff (rst || global_preload_pulse)
		(arith_taken && !sum_select)
			|=> accumulated_bit == ($past(accumulated_bit) ^ $past(operand_bit)
				^ !$past(carry_borrow_in))
	) else $error("difference mode stored a wrong bit");

	// RULE8 carry tracks inputs in the same cycle
	a_carry_live: assert property ( // RULE8
		@(posedge clk) disable iff (rst || global_preload_pulse)
		$changed(operand_bit) && $stable(accumulated_bit) && $stable(carry_borrow_in)
			&& $stable(sum_select) && (accumulated_bit != carry_borrow_in)
			|-> $changed(carry_borrow_out)
	) else $error("carry output did not follow the operand at once");

	// RULE9 high-true carry
	a_sum_carry: assert property ( // RULE9
		@(posedge clk) disable iff (rst || global_preload_pulse)
		sum_select |-> carry_borrow_out ==
			((2'(accumulated_bit) + 2'(operand_bit) + 2'(carry_borrow_in)) > 2'd1)
	) else $error("sum mode carry out is wrong");

	// RULE10 low-true borrow
	a_diff_borrow: assert property ( // RULE10
		@(posedge clk) disable iff (rst || global_preload_pulse)
		!sum_select |-> !carry_borrow_out ==
			((2'(operand_bit) + 2'(!carry_borrow_in)) > 2'(accumulated_bit))
	) else $error("difference mode borrow out is wrong");

	// RULE12 load beats arithmetic
	a_load_priority: assert property ( // RULE12
		@(posedge clk) disable iff (rst || global_preload_pulse)
		(!sync_clear && load_select && eff_enable && (arith_bit != load_value_bit))
			|=> (accumulated_bit == $past(load_value_bit)) && (carry_count_reg
				== $past(carry_count_reg) || $past(wr_carry_count))
	) else $error("arithmetic overrode a load");

	// Hold bit blocks arithmetic for as long as it is set
	a_hold_blocks: assert property (
		@(posedge clk) disable iff (rst || global_preload_pulse)
		hold_reg && !sync_clear && !load_select ##1 !rst |-> $stable(accumulated_bit)
	) else $error("arithmetic ran while hold was set");

	// Read data stands one cycle only
	a_read_window: assert property (
		@(posedge clk) disable iff (rst)
		!reg_rd |=> reg_rdata == '0
	) else $error("read data outside its cycle");

	// Every load or arithmetic edge without a count write adds one to the update count
	a_update_counts: assert property (
		@(posedge clk) disable iff (rst)
		bit_written && !wr_update_count
			|=> update_count_reg == $past(update_count_reg) + 1'b1
	) else $error("update count did not step on a bit write");

	// A write clears the update count when no event lands with it
	a_update_clears: assert property (
		@(posedge clk) disable iff (rst)
		wr_update_count && !bit_written |=> update_count_reg == '0
	) else $error("write did not clear the update count");

	// Carry is high-true in sum mode, borrow low-true in difference mode
	a_carry_counts: assert property ( // RULE9 RULE10
		@(posedge clk) disable iff (rst)
		arith_taken && (carry_borrow_out == sum_select) && !wr_carry_count
			|=> carry_count_reg == $past(carry_count_reg) + 1'b1
	) else $error("carry count did not step on a carry or borrow");

	// With no arithmetic edge a write leaves the carry count at zero
	a_carry_clears: assert property (
		@(posedge clk) disable iff (rst)
		wr_carry_count && !arith_taken |=> carry_count_reg == '0
	) else $error("write did not clear the carry count");

	// Control write lands in the hold bit one cycle later
	a_hold_write: assert property (
		@(posedge clk) disable iff (rst)
		wr_control |=> hold_reg == $past(reg_wdata[acc_stage_pkg::CTL_HOLD_BIT])
	) else $error("control write did not set the hold bit");

	// Status writes and preload pulses must leave the hold bit alone
	a_hold_steady: assert property (
		@(posedge clk) disable iff (rst)
		!wr_control |=> $stable(hold_reg)
	) else $error("hold bit moved without a control write");

	// Status word reflects the strobe cycle, unused bits zero
	a_status_read: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && sel_status |=> reg_rdata[acc_stage_pkg::ST_ACC_BIT] == $past(stored_bit)
			&& reg_rdata[acc_stage_pkg::ST_HOLD_BIT] == $past(hold_reg)
			&& reg_rdata[acc_stage_pkg::DATA_W-1:acc_stage_pkg::ST_ENABLE_BIT+1] == '0
	) else $error("status read returned a wrong word");

	// Control word carries only the hold bit
	a_control_read: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && sel_control |=> reg_rdata[acc_stage_pkg::CTL_HOLD_BIT] == $past(hold_reg)
			&& reg_rdata[acc_stage_pkg::DATA_W-1:acc_stage_pkg::CTL_HOLD_BIT+1] == '0
	) else $error("control read returned a wrong word");

	// Update count read, zero above the counter width
	a_count_read: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && sel_update_count |=> reg_rdata[COUNT_W-1:0] == $past(update_count_reg)
			&& reg_rdata[acc_stage_pkg::DATA_W-1:COUNT_W] == '0
	) else $error("update count read returned a wrong word");

	// Carry count read, zero above the counter width
	a_carry_read: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && sel_carry_count |=> reg_rdata[COUNT_W-1:0] == $past(carry_count_reg)
			&& reg_rdata[acc_stage_pkg::DATA_W-1:COUNT_W] == '0
	) else $error("carry count read returned a wrong word");

	// Offsets outside the map read as zero so software sees no stale data
	a_unmapped_zero: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && !sel_status && !sel_control && !sel_update_count && !sel_carry_count
			|=> reg_rdata == '0
	) else $error("unmapped read returned nonzero data");
endmodule

// *** hdl/acc_stage_pkg.sv ***
// Shared constants for the one-bit loadable accumulator stage.
package acc_stage_pkg;
	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_UPDATE_COUNT = 8'h08;
	localparam logic [7:0] OFF_CARRY_COUNT = 8'h0C;

	// Status field positions
	localparam int ST_ACC_BIT = 0;
	localparam int ST_CARRY_BIT = 1;
	localparam int ST_SUM_BIT = 2;
	localparam int ST_HOLD_BIT = 3;
	localparam int ST_ENABLE_BIT = 4;

	// Control field positions
	localparam int CTL_HOLD_BIT = 0;

	// Reset values
	localparam logic ACC_RESET = 1'b0;
	localparam logic HOLD_RESET = 1'b0;
endpackage

// *** hdl/acc_bit_cell.sv ***
// Combinational one-bit add/subtract cell with carry or borrow output.
`timescale 1ns/1ps
module acc_bit_cell (
	input logic stored_bit,
	input logic operand_bit,
	input logic carry_borrow_in,
	input logic sum_select,
	output logic arith_bit,
	output logic carry_borrow_out
);
	// Subtraction is addition of the inverted operand; borrow is then active low
	logic eff_operand;

	// Operand steering by mode
	assign eff_operand = sum_select ? operand_bit : ~operand_bit;

	// Result bit and majority carry, never registered so stages can ripple
	assign arith_bit = stored_bit ^ eff_operand ^ carry_borrow_in;
	assign carry_borrow_out = (stored_bit & eff_operand) |
		(stored_bit & carry_borrow_in) |
		(eff_operand & carry_borrow_in);
endmodule

// *** hdl/acc_bit_store.sv ***
// One-bit storage with async preload clear and clear/load/enable priority.
`timescale 1ns/1ps
module acc_bit_store (
	input logic clk,
	input logic rst,
	input logic preload,
	input logic clear,
	input logic load,
	input logic enable,
	input logic load_bit,
	input logic arith_bit,
	output logic stored_bit
);
	logic bit_reg;
	logic bit_next;

	// Next value: reset and clear first, then load, then arithmetic, else hold
	always_comb begin
		if (rst || clear) begin
			bit_next = acc_stage_pkg::ACC_RESET;
		end else if (load) begin
			bit_next = load_bit;
		end else if (enable) begin
			bit_next = arith_bit;
		end else begin
			bit_next = bit_reg;
		end
	end

	// Preload acts without the clock so the bit is low before any edge
	always_ff @(posedge clk or posedge preload) begin
		if (preload) begin
			bit_reg <= acc_stage_pkg::ACC_RESET;
		end else begin
			bit_reg <= bit_next;
		end
	end

	assign stored_bit = bit_reg;
endmodule

// *** tb/chain_next_stage.sv ***
// Behavioural next accumulator stage that takes the stage's carry output.
`timescale 1ns/1ps
module chain_next_stage (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic sum_select,
	input wire logic carry_in,
	output logic next_bit
);
	logic [1:0] total;

	// carry or borrow polarity
	// Operand held at zero, so only the chained carry or borrow moves this bit
	assign total = sum_select ? {1'b0, next_bit} + {1'b0, carry_in}
		: {1'b0, next_bit} - {1'b0, ~carry_in};

	always_ff @(posedge clk) begin
		if (rst) begin
			next_bit <= 1'b0;
		end else if (enable) begin
			next_bit <= total[0];
		end
	end
endmodule

// *** tb/one_bit_acc_stage_tb.sv ***
// Self-checking bench for the one-bit accumulator stage and its chained neighbour.
`timescale 1ns/1ps
module one_bit_acc_stage_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pre = 1'b0, clr = 1'b0, en = 1'b0, ld = 1'b0, sm = 1'b0, lv = 1'b0, b = 1'b0, ci = 1'b0;
	logic q, co, nq;
	logic wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic q_exp = 1'b0, nq_exp = 1'b0, hold_exp = 1'b0;
	int bad_count = 0;
	int n_tests = 0;

	always #5 clk = ~clk;

	one_bit_acc_stage one_bit_acc_stage_inst (.clk(clk), .rst(rst), .global_preload_pulse(pre),
		.sync_clear(clr), .stage_enable(en), .load_select(ld), .sum_select(sm),
		.load_value_bit(lv), .operand_bit(b), .carry_borrow_in(ci), .accumulated_bit(q),
		.carry_borrow_out(co), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata));

	chain_next_stage chain_next_stage_inst (.clk(clk), .rst(rst), .enable(en),
		.sum_select(sm), .carry_in(co), .next_bit(nq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One datapath request; carry checked before the edge, bits after it
	task automatic op(input logic c, l, e, s, d, o, i);
		int t;
		logic co_exp;
		@(posedge clk);
		clr <= c;
		ld <= l;
		en <= e;
		sm <= s;
		lv <= d;
		b <= o;
		ci <= i;
		#1;
		t = s ? q_exp + o + i : q_exp - o - !i;
		co_exp = s ? t > 1 : t >= 0;
		chk(co, co_exp);
		@(posedge clk);
		clr <= 1'b0;
		ld <= 1'b0;
		en <= 1'b0;
		if (c) q_exp = 1'b0;
		else if (l) q_exp = d;
		else if (e && !hold_exp) q_exp = t[0];
		if (e) nq_exp = s ? nq_exp ^ co_exp : nq_exp ^ !co_exp;
		#1;
		chk(q, q_exp);
		chk(nq, nq_exp);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic t_reset;
		chk(q, 1'b0);
		rd_reg(acc_stage_pkg::OFF_STATUS, 32'h0);
		rd_reg(acc_stage_pkg::OFF_CONTROL, 32'h0);
		rd_reg(8'h10, 32'h0);
	endtask

	task automatic t_load;
		op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		op(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
	endtask

	// Every mode, operand, carry and stored bit, each from a fresh load
	task automatic t_arith;
		logic [3:0] v;
		for (int k = 0; k < 16; k++) begin
			v = k[3:0];
			op(1'b0, 1'b1, 1'b0, v[3], v[0], 1'b0, 1'b0);
			op(1'b0, 1'b0, 1'b1, v[3], 1'b0, v[1], v[2]);
		end
	endtask

	// Enable low, then the hold bit, both must freeze the stored bit
	task automatic t_hold;
		op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		op(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		wr_reg(acc_stage_pkg::OFF_CONTROL, 32'h1);
		hold_exp = 1'b1;
		rd_reg(acc_stage_pkg::OFF_CONTROL, 32'h1);
		op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		rd_reg(acc_stage_pkg::OFF_STATUS, 32'h0F);
		wr_reg(acc_stage_pkg::OFF_STATUS, 32'h0);
		rd_reg(acc_stage_pkg::OFF_CONTROL, 32'h1);
		wr_reg(acc_stage_pkg::OFF_CONTROL, 32'h0);
		hold_exp = 1'b0;
	endtask

	task automatic t_clear;
		op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
	endtask

	// Preload clears at once, with no clock edge needed
	task automatic t_preload;
		op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		@(posedge clk);
		pre <= 1'b1;
		#1;
		chk(q, 1'b0);
		q_exp = 1'b0;
		@(posedge clk);
		pre <= 1'b0;
	endtask

	// Counters from zero: loads and arithmetic step the update count, carries and borrows the carry count, clear neither
	task automatic t_counts;
		wr_reg(acc_stage_pkg::OFF_UPDATE_COUNT, 32'h0);
		wr_reg(acc_stage_pkg::OFF_CARRY_COUNT, 32'h0);
		op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		op(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		rd_reg(acc_stage_pkg::OFF_UPDATE_COUNT, 32'h4);
		rd_reg(acc_stage_pkg::OFF_CARRY_COUNT, 32'h2);
	endtask

	task automatic conclude;
		if (bad_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole run is about 130 cycles; this span leaves wide margin
	initial begin
		#20000;
		bad_count++;
		conclude();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_load();
		t_arith();
		t_hold();
		t_clear();
		t_counts();
		t_preload();
		conclude();
	end
endmodule
